// ### bench/mem_model.sv
// Purpose: Memory-side partner that answers DMA read and write cycles.
// Assumes: One request at a time, held by the DMA until ready is seen.
// Notes:   Read data is the address xor a pattern; idle data toggles.
module mem_model (
  input  wire logic              i_clk,
  input  wire dma_pkg::mem_req_t i_mem,
  input  wire logic [1:0]        i_lat,
  output logic                   o_ready,
  output logic      [15:0]       o_rdata,
  output logic      [25:0]       o_waddr,
  output logic      [15:0]       o_wdata,
  output logic      [7:0]        o_nwr
);
  timeunit 1ns;
  timeprecision 1ps;
  import dma_pkg::*;
  logic [1:0] wait_cnt;

  initial begin
    o_ready  = 1'b0;
    o_rdata  = 16'hA5A5;
    o_waddr  = '0;
    o_wdata  = 16'h0000;
    o_nwr    = 8'h00;
    wait_cnt = 2'h0;
  end

  always @(posedge i_clk) begin
    if (o_ready) begin
      o_ready  <= 1'b0;
      // Released data must not keep looking valid
      o_rdata  <= ~o_rdata;
      wait_cnt <= 2'h0;
      if (i_mem.write) begin
        o_waddr <= i_mem.addr;
        o_wdata <= i_mem.wdata;
        o_nwr   <= o_nwr + 8'h01;
      end
    end else if (i_mem.valid && wait_cnt >= i_lat) begin
      o_ready <= 1'b1;
      o_rdata <= i_mem.write ? ~o_rdata : i_mem.addr[15:0] ^ 16'h5A5A;
    end else begin
      wait_cnt <= i_mem.valid ? wait_cnt + 2'h1 : 2'h0;
      o_rdata  <= ~o_rdata;
    end
  end
endmodule // mem_model

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the four-channel DMA controller.
// Assumes: APB master per bus rules; memory side played by mem_model.
// Notes:   Channel n registers sit at byte address 0x20 * n.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, ready;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] trig;
  mem_req_t    mem;
  logic [15:0] mrdata, wdata;
  logic [25:0] waddr;
  logic [7:0]  nwr;
  logic [2:0]  hold;
  logic [3:0]  irq, irq_seen;
  logic [1:0]  lat;
  int          num_errors, checked, k;

  dma_ctrl u_dma_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_trig_req(trig), .o_mem(mem),
    .i_mem_ready(ready), .i_mem_rdata(mrdata), .o_cpu_hold(hold),
    .o_transfer_end_irq(irq));
  mem_model u_mem_model (.i_clk(clk), .i_mem(mem), .i_lat(lat),
    .o_ready(ready), .o_rdata(mrdata), .o_waddr(waddr), .o_wdata(wdata),
    .o_nwr(nwr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (rst_n) irq_seen <= irq_seen | irq;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Channel control goes last so the channel wakes fully programmed
  task automatic cfg(input logic [11:0] b, input logic [15:0] v[8]);
    for (int i = 0; i < 6; i++) wr(b + 12'(4 * i), {16'h0, v[i]});
    wr(b + 12'h01C, {16'h0, v[7]});
    wr(b + 12'h018, {16'h0, v[6]});
  endtask
  task automatic wait_wr(input logic [7:0] n);
    for (k = 0; k < 300 && nwr < n; k++) @(posedge clk);
    if (nwr < n) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic pulse(input logic [63:0] t);
    trig <= t;
    @(posedge clk);
    trig <= 64'h0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_map();
    apb(1'b0, 12'h080, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    rchk(12'h018, 32'h0);
  endtask
  task automatic test_soft();
    lat = 2'h2;
    cfg(12'h020, '{16'h0123, 16'h0200, 16'h0040, 16'h0300, 16'h0001,
                   16'h4000, 16'h0001, 16'h0000});
    wr(12'h038, 32'h5);
    for (k = 0; k < 20 && mem.valid !== 1'b1; k++) @(posedge clk);
    check({29'h0, hold}, 32'h3);
    wait_wr(8'h01);
    check({6'h0, waddr}, 32'h3000040);
    check({16'h0, wdata}, 32'h5B78);
    wr(12'h038, 32'h5);
    wait_wr(8'h02);
    check({6'h0, waddr}, 32'h3000042);
    check({16'h0, wdata}, 32'h5B7E);
    for (k = 0; k < 20 && irq_seen[1] !== 1'b1; k++) @(posedge clk);
    check({28'h0, irq_seen}, 32'h2);
    check({29'h0, hold}, 32'h0);
    rchk(12'h038, 32'h80);
    rchk(12'h038, 32'h0);
    rchk(12'h038, 32'h0);
    rchk(12'h038, 32'h0);
    rchk(12'h030, 32'h1);
  endtask
  task automatic test_hw();
    lat = 2'h3;
    cfg(12'h040, '{16'h0010, 16'h0000, 16'h0100, 16'h0000, 16'h0001,
                   16'h4000, 16'h0001, 16'h0005});
    pulse(64'h20);
    rchk(12'h05C, 32'h85);
    check({29'h0, hold}, 32'h4);
    wait_wr(8'h03);
    rchk(12'h05C, 32'h05);
    check({16'h0, wdata}, 32'h5A4A);
    wr(12'h058, 32'h0);
    pulse(64'h20);
    // No completion to wait for while paused, so a fixed quiet spell
    repeat (20) @(posedge clk);
    check({24'h0, nwr}, 32'h3);
    wr(12'h058, 32'h1);
    pulse(64'h20);
    wait_wr(8'h04);
    check({6'h0, waddr}, 32'h0000102);
    check({16'h0, wdata}, 32'h5A48);
  endtask
  task automatic test_prio();
    lat = 2'h1;
    cfg(12'h060, '{16'h0020, 16'h0200, 16'h0030, 16'h0300, 16'h0000,
                   16'h4000, 16'h0001, 16'h0002});
    cfg(12'h000, '{16'h0000, 16'h0200, 16'h0010, 16'h0300, 16'h0000,
                   16'h4000, 16'h0001, 16'h0001});
    pulse(64'h6);
    wait_wr(8'h05);
    check({6'h0, waddr}, 32'h3000010);
    wait_wr(8'h06);
    check({6'h0, waddr}, 32'h3000030);
  endtask
  task automatic test_init();
    rchk(12'h018, 32'h80);
    rchk(12'h018, 32'h0);
    rchk(12'h018, 32'h0);
    cfg(12'h000, '{16'h0000, 16'h0200, 16'h0010, 16'h0300, 16'h0003,
                   16'h4000, 16'h0001, 16'h0000});
    wr(12'h018, 32'h5);
    wait_wr(8'h07);
    rchk(12'h010, 32'h2);
    rchk(12'h000, 32'h2);
    rchk(12'h01C, 32'h0);
    wr(12'h018, 32'h0);
    wr(12'h018, 32'h0);
    wr(12'h018, 32'h0);
    wr(12'h018, 32'h2);
    rchk(12'h010, 32'h3);
    rchk(12'h078, 32'h80);
    wr(12'h078, 32'h0);
    rchk(12'h078, 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig = 64'h0;
    lat = 2'h0;
    irq_seen = 4'h0;
    num_errors = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_map();
    test_soft();
    test_hw();
    test_prio();
    test_init();
    end_sim();
  end
endmodule // tb_top

// ### core/dma_chan.sv
// Purpose: One DMA channel: registers, trigger capture, counting.
// Assumes: Register access strobes are one-cycle pulses from the APB slave.
// Notes:   A done pulse in the same cycle as init beats the init.
`include "dma_regs.svh"
module dma_chan #(
  parameter int NUM_TRIG = 64
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic [2:0]            i_idx,
  input  wire logic [15:0]           i_wdata,
  input  wire logic [NUM_TRIG-1:0]   i_trig_vec,
  input  wire logic                  i_done,
  output dma_pkg::chan_view_t        o_view,
  output logic      [15:0]           o_rdata,
  output logic                       o_transfer_end_irq
);
  import dma_pkg::*;

  logic [15:0] src_lo, src_hi, dst_lo, dst_hi, init_cnt, cur_cnt, adc;
  logic [5:0]  trig_sel;
  logic        en, tc, pend, irq;
  logic [15:0] next_src_lo, next_src_hi, next_dst_lo, next_dst_hi;
  logic [15:0] next_init_cnt, next_cur_cnt, next_adc;
  logic [5:0]  next_trig_sel;
  logic        next_en, next_tc, next_pend, next_irq;
  logic        ctl_wr, sw_trig, hw_trig, do_init;
  logic [25:0] src, dst, step;

  assign src  = {src_hi[`HI_ADDR_W-1:0], src_lo};
  assign dst  = {dst_hi[`HI_ADDR_W-1:0], dst_lo};
  assign step = adc[`ADC_SIZE] ? 26'h0000002 : 26'h0000001;
  assign ctl_wr  = i_wr && (i_idx == `IDX_CHCTL);
  assign sw_trig = ctl_wr && i_wdata[`CHCTL_SWTRIG];
  assign hw_trig = (trig_sel != 6'h00) && i_trig_vec[trig_sel];
  assign do_init = ctl_wr && i_wdata[`CHCTL_INIT] && !i_done;

  function automatic logic [25:0] stepped(input logic [25:0] a,
                                          input logic [1:0]  dir,
                                          input logic [25:0] s);
    case (dir)
      `DIR_INC: stepped = a + s;
      `DIR_DEC: stepped = a - s;
      default:  stepped = a;
    endcase
  endfunction

  always_comb begin
    logic [25:0] ns, nd;
    ns = stepped(src, adc[`ADC_SDIR_HI:`ADC_SDIR_LO], step);
    nd = stepped(dst, adc[`ADC_DDIR_HI:`ADC_DDIR_LO], step);
    next_src_lo = src_lo;
    next_src_hi = src_hi;
    next_dst_lo = dst_lo;
    next_dst_hi = dst_hi;
    next_init_cnt = init_cnt;
    next_cur_cnt = cur_cnt;
    next_adc = adc;
    next_trig_sel = trig_sel;
    next_en = en;
    next_tc = tc;
    next_pend = pend;
    next_irq = 1'b0;
    if (i_wr) begin
      case (i_idx)
        `IDX_SRC_LO:  next_src_lo = i_wdata;
        `IDX_SRC_HI:  next_src_hi = {6'h00, i_wdata[`HI_ADDR_W-1:0]};
        `IDX_DST_LO:  next_dst_lo = i_wdata;
        `IDX_DST_HI:  next_dst_hi = {6'h00, i_wdata[`HI_ADDR_W-1:0]};
        `IDX_COUNT: begin
          next_init_cnt = i_wdata;
          next_cur_cnt = i_wdata;
        end
        `IDX_ADDRCTL: next_adc = i_wdata & 16'h40F0;
        `IDX_CHCTL:   next_en = i_wdata[`CHCTL_EN];
        `IDX_TRIGSEL: next_trig_sel = i_wdata[`TRIG_FIELD_W-1:0];
        default: ;
      endcase
    end
    if (i_rd && i_idx == `IDX_CHCTL)
      next_tc = 1'b0;
    // Requests while one is pending are dropped
    if ((sw_trig || hw_trig) && en && !tc && !pend)
      next_pend = 1'b1;
    if (i_done) begin
      next_pend = 1'b0;
      {next_src_hi[`HI_ADDR_W-1:0], next_src_lo} = ns;
      {next_dst_hi[`HI_ADDR_W-1:0], next_dst_lo} = nd;
      if (cur_cnt == 16'h0000) begin
        next_en = 1'b0;
        next_tc = 1'b1;
        next_irq = 1'b1;
        next_cur_cnt = init_cnt;
      end else begin
        next_cur_cnt = cur_cnt - 16'h0001;
      end
    end
    if (do_init) begin
      next_en = 1'b0;
      next_tc = 1'b0;
      next_pend = 1'b0;
      next_cur_cnt = init_cnt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      src_lo <= `RST_HALF;
      src_hi <= `RST_HALF;
      dst_lo <= `RST_HALF;
      dst_hi <= `RST_HALF;
      init_cnt <= `RST_HALF;
      cur_cnt <= `RST_HALF;
      adc <= `RST_HALF;
      trig_sel <= 6'h00;
      en <= 1'b0;
      tc <= 1'b0;
      pend <= 1'b0;
      irq <= 1'b0;
    end else begin
      src_lo <= next_src_lo;
      src_hi <= next_src_hi;
      dst_lo <= next_dst_lo;
      dst_hi <= next_dst_hi;
      init_cnt <= next_init_cnt;
      cur_cnt <= next_cur_cnt;
      adc <= next_adc;
      trig_sel <= next_trig_sel;
      en <= next_en;
      tc <= next_tc;
      pend <= next_pend;
      irq <= next_irq;
    end
  end

  assign o_view = '{req: en && pend, half: adc[`ADC_SIZE],
                    src: src, dst: dst};
  assign o_transfer_end_irq = irq;

  always_comb begin
    case (i_idx)
      `IDX_SRC_LO:  o_rdata = src_lo;
      `IDX_SRC_HI:  o_rdata = src_hi;
      `IDX_DST_LO:  o_rdata = dst_lo;
      `IDX_DST_HI:  o_rdata = dst_hi;
      `IDX_COUNT:   o_rdata = cur_cnt;
      `IDX_ADDRCTL: o_rdata = adc;
      `IDX_CHCTL:   o_rdata = {8'h00, tc, 6'h00, en};
      default:      o_rdata = {8'h00, pend, 1'b0, trig_sel};
    endcase
  end

  tc_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_done && cur_cnt == 16'h0000 |=> tc && !en && irq)
    else $error("terminal count did not set flag");
  pend_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_done |=> !pend)
    else $error("pending flag kept after transfer");
  tc_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tc && !(i_rd && i_idx == `IDX_CHCTL) && !do_init |=> tc)
    else $error("complete flag lost without read");
  init_cnt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    do_init |=> cur_cnt == $past(init_cnt) && !en && !tc)
    else $error("init did not restore count");
endmodule // dma_chan

// ### core/dma_ctrl.sv
// Purpose: Four-channel DMA controller with APB registers.
// Assumes: Memory bus answers with i_mem_ready; CPU honours hold outputs.
// Notes:   Address bits 25:24 select the region: RAM, peripheral, external.
`include "dma_regs.svh"
module dma_ctrl #(
  parameter int NUM_CH   = 4,
  parameter int NUM_TRIG = 64
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [11:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic                      o_pready,
  output logic      [31:0]          o_prdata,
  output logic                      o_pslverr,
  input  wire logic [NUM_TRIG-1:0]  i_trig_req,
  output dma_pkg::mem_req_t         o_mem,
  input  wire logic                 i_mem_ready,
  input  wire logic [15:0]          i_mem_rdata,
  output logic      [2:0]           o_cpu_hold,
  output logic      [NUM_CH-1:0]    o_transfer_end_irq
);
  import dma_pkg::*;

  // ****************************************
  // APB slave
  // ****************************************
  logic                    pready, pslverr, next_pready, next_pslverr;
  logic [31:0]             prdata, next_prdata;
  logic                    access, unmapped, reg_wr, reg_rd;
  logic [1:0]              sel_ch;
  logic [2:0]              sel_idx;
  logic [NUM_CH-1:0][15:0] ch_rdata;

  assign access   = i_psel && i_penable;
  assign unmapped = i_paddr >= `MAP_LIMIT;
  assign sel_ch   = i_paddr[`CH_SHIFT+1:`CH_SHIFT];
  assign sel_idx  = i_paddr[4:2];
  // Side effects only at the completing edge
  assign reg_wr   = access && pready && i_pwrite && !unmapped;
  assign reg_rd   = access && pready && !i_pwrite && !unmapped;

  always_comb begin
    next_pready  = access && !pready;
    next_pslverr = access && !pready && unmapped;
    next_prdata  = prdata;
    if (access && !pready)
      next_prdata = (unmapped || i_pwrite) ? 32'h00000000
                                           : {16'h0000, ch_rdata[sel_ch]};
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  assign o_pready  = pready;
  assign o_pslverr = pslverr;
  assign o_prdata  = prdata;

  // ****************************************
  // Channels
  // ****************************************
  chan_view_t [NUM_CH-1:0] view;
  logic       [NUM_CH-1:0] done_vec;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    dma_chan #(.NUM_TRIG(NUM_TRIG)) u_chan (
      .i_clk              (i_clk),
      .i_rst_n            (i_rst_n),
      .i_wr               (reg_wr && sel_ch == 2'(c)),
      .i_rd               (reg_rd && sel_ch == 2'(c)),
      .i_idx              (sel_idx),
      .i_wdata            (i_pwdata[15:0]),
      .i_trig_vec         (i_trig_req),
      .i_done             (done_vec[c]),
      .o_view             (view[c]),
      .o_rdata            (ch_rdata[c]),
      .o_transfer_end_irq (o_transfer_end_irq[c])
    );
  end

  // ****************************************
  // Arbitration and transfer sequencer
  // ****************************************
  xfer_state_t state, next_state;
  logic [1:0]  act, next_act, win;
  logic        any_req;
  logic [15:0] buf_data, next_buf;
  mem_req_t    mem, next_mem;
  logic [2:0]  hold, next_hold;
  logic        fin;

  always_comb begin
    win = 2'h0;
    any_req = 1'b0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (view[c].req) begin
        win = c[1:0];
        any_req = 1'b1;
      end
    end
  end

  function automatic logic [2:0] region(input logic [25:0] a);
    case (a[25:24])
      `REGION_RAM:  region = 3'b001;
      `REGION_PERI: region = 3'b010;
      default:      region = 3'b100;
    endcase
  endfunction

  function automatic logic [25:0] aligned(input logic [25:0] a,
                                          input logic        half);
    aligned = half ? {a[25:1], 1'b0} : a;
  endfunction

  assign fin = (state == S_WRITE) && i_mem_ready;

  always_comb begin
    next_state = state;
    next_act   = act;
    next_buf   = buf_data;
    next_mem   = mem;
    next_hold  = hold;
    done_vec   = '0;
    case (state)
      S_IDLE: begin
        // Priority is taken afresh before every transfer, not before its write cycle
        if (any_req) begin
          next_act   = win;
          next_state = S_READ;
          next_mem   = '{valid: 1'b1, write: 1'b0, half: view[win].half,
                         addr: aligned(view[win].src, view[win].half),
                         wdata: 16'h0000};
          next_hold  = region(view[win].src) | region(view[win].dst);
        end
      end
      S_READ: begin
        if (i_mem_ready) begin
          next_buf   = i_mem_rdata;
          next_mem   = '0;
          next_state = S_GAP;
        end
      end
      S_GAP: begin
        next_state = S_WRITE;
        next_mem   = '{valid: 1'b1, write: 1'b1, half: view[act].half,
                       addr: aligned(view[act].dst, view[act].half),
                       wdata: buf_data};
      end
      S_WRITE: begin
        if (i_mem_ready) begin
          done_vec[act] = 1'b1;
          next_mem   = '0;
          next_hold  = 3'b000;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state    <= S_IDLE;
      act      <= 2'h0;
      buf_data <= 16'h0000;
      mem      <= '0;
      hold     <= 3'b000;
    end else begin
      state    <= next_state;
      act      <= next_act;
      buf_data <= next_buf;
      mem      <= next_mem;
      hold     <= next_hold;
    end
  end

  assign o_mem = mem;
  // Only regions touched by this transfer are held from the CPU
  assign o_cpu_hold = hold;

  // ****************************************
  // Checks
  // ****************************************
  logic act_region_free;
  assign act_region_free = view[act].src[25:24] != `REGION_RAM &&
                           view[act].dst[25:24] != `REGION_RAM &&
                           state == S_READ;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  gap_seq_a: assert property (
    state == S_READ && i_mem_ready |=> !o_mem.valid ##1
    o_mem.valid && o_mem.write)
    else $error("idle clock missing between read and write");
  prio_zero_a: assert property (
    state == S_IDLE && view[0].req |=> act == 2'h0 && state == S_READ)
    else $error("channel zero not served first");
  half_align_a: assert property (
    o_mem.valid && o_mem.half |-> !o_mem.addr[0])
    else $error("odd address on halfword access");
  hold_busy_a: assert property (
    state != S_IDLE |-> o_cpu_hold != 3'b000)
    else $error("bus not held during transfer");
  ram_free_a: assert property (
    state != S_IDLE && act_region_free |-> !o_cpu_hold[0])
    else $error("internal RAM held though unused");
  apb_wait_a: assert property (
    access && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");
  done_once_a: assert property (
    fin |-> $onehot(done_vec) ##1 state == S_IDLE)
    else $error("transfer finish not signalled once");
endmodule // dma_ctrl

// ### core/dma_pkg.sv
// Purpose: Types shared by the DMA controller and its channels.
// Assumes: dma_regs.svh supplies the numbers.
// Notes:   Addresses are 26 bits wide.
package dma_pkg;
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_READ  = 2'b01,
    S_GAP   = 2'b10,
    S_WRITE = 2'b11
  } xfer_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        half;
    logic [25:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        req;
    logic        half;
    logic [25:0] src;
    logic [25:0] dst;
  } chan_view_t;
endpackage

// ### core/dma_regs.svh
// Purpose: Register offsets, field positions and reset values of the DMA.
// Assumes: APB, 32-bit words, one aligned word per register.
// Notes:   Byte address = channel * 32 + register index * 4.
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH

// ****************************************
// Register indices inside one channel
// ****************************************
`define IDX_SRC_LO   3'h0
`define IDX_SRC_HI   3'h1
`define IDX_DST_LO   3'h2
`define IDX_DST_HI   3'h3
`define IDX_COUNT    3'h4
`define IDX_ADDRCTL  3'h5
`define IDX_CHCTL    3'h6
`define IDX_TRIGSEL  3'h7
`define CH_SHIFT     5
`define MAP_LIMIT    12'h080

// ****************************************
// Field positions
// ****************************************
`define CHCTL_EN     0
`define CHCTL_INIT   1
`define CHCTL_SWTRIG 2
`define CHCTL_TC     7
`define ADC_SIZE     14
`define ADC_SDIR_HI  7
`define ADC_SDIR_LO  6
`define ADC_DDIR_HI  5
`define ADC_DDIR_LO  4
`define TRIG_PEND    7
`define HI_ADDR_W    10
`define TRIG_FIELD_W 6

// ****************************************
// Reset values, directions, address regions
// ****************************************
`define RST_HALF     16'h0000
`define DIR_INC      2'h0
`define DIR_DEC      2'h1
`define REGION_RAM   2'h2
`define REGION_PERI  2'h3

`endif
